/* logic/awe_pkg.sv */
// Constants, register map and carrier types for the asynchronous wait, ECC and interrupt block.
// Assumes a classic Wishbone slave port with 32-bit data and word-aligned registers.
// Operation
// R1: Setting nand_mode_enable puts chip-select space 2 into NAND mode with ECC and status.
// R2: In NAND mode, accumulate ECC parity over NAND data, at most 512 bytes per run.
// R3: Software sets ecc_start before the transfer and reads the result after it.
// R4: Software moves no more than 512 bytes per ECC run, else the result is invalid.
// R5: Reading the ECC result register clears ecc_start.
// R6: Writing 1 to ecc_start clears the ECC result before accumulation.
// R7: Column and row parities split at p4e/p8e for 8-bit, p8e/p16e for 16-bit.
// R8: Software ignores unused high row parities for runs shorter than 512 bytes.
// R9: In NAND mode, nand_ready_status shows the raw wait_input level.
// R10: Every rising edge of wait_input sets the wait-rise raw status bit.
// R11: wait_polarity affects neither nand_ready_status nor wait-rise detection.
// R12: With extended_wait_enable set, wait_input is sampled during strobe to stretch it.
// R13: While wait is asserted add strobe cycles, then resume at the last strobe cycle.
// R14: Extension is limited to max_wait_count cycles; on expiry go to hold and flag timeout.
// R15: wait_polarity 1 (reset) waits on high input, 0 waits on low input.
// R16: Software keeps both strobe lengths nonzero when using extended wait.
// R17: Idle data bus is parked on last write data, released only for reads.
// R18: A read during SDRAM self-refresh leaves the data bus tri-stated afterwards.
// R19: Pin reset, watchdog timeout or emulator reset resets the block and registers.
// R20: After any reset the SDRAM initialisation request is raised automatically.
// R21: One interrupt output, sourced by wait rise and asynchronous timeout.
// R22: Enable set and clear registers take write-1 actions and both read current enables.
// R23: Raw bits set regardless of enable, masked bits only when enabled; W1 clears both.
// R24: Interrupt output is high while any masked status bit is set.
package awe_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_NAND_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ECC_RESULT   = 8'h04;
  localparam logic [7:0] OFF_NAND_READY   = 8'h08;
  localparam logic [7:0] OFF_WAIT_CFG     = 8'h0C;
  localparam logic [7:0] OFF_ASYNC_CFG    = 8'h10;
  localparam logic [7:0] OFF_IRQ_RAW      = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASKED   = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN_SET   = 8'h1C;
  localparam logic [7:0] OFF_IRQ_EN_CLEAR = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int NAND_EN_BIT   = 0;
  localparam int BUS16_BIT     = 1;
  localparam int ECC_START_BIT = 8;
  localparam int MAX_WAIT_LSB  = 0;
  localparam int MAX_WAIT_W    = 8;
  localparam int WAIT_POL_BIT  = 28;
  localparam int EXT_WAIT_BIT  = 30;
  localparam int W_STROBE_LSB  = 0;
  localparam int R_STROBE_LSB  = 6;
  localparam int STROBE_W      = 6;
  localparam int SETUP_LSB     = 12;
  localparam int HOLD_LSB      = 16;
  localparam int PHASE_W       = 4;
  localparam int IRQ_WR_BIT    = 0;
  localparam int IRQ_AT_BIT    = 1;

  // ==========================================================================
  // Reset values and sizes
  localparam logic                  WAIT_POL_RST = 1'b1;
  localparam logic [MAX_WAIT_W-1:0] MAX_WAIT_RST = 8'h80;
  localparam logic [STROBE_W-1:0]   STROBE_RST   = 6'h3F;
  localparam logic [PHASE_W-1:0]    PHASE_RST    = 4'hF;
  localparam int                    ECC_W        = 24;
  localparam int                    MEM_W        = 16;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } awe_wb_req_t;

  typedef struct packed {
    logic             write;
    logic             cs2;
    logic [MEM_W-1:0] wdata;
  } awe_acc_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } awe_state_t;

endpackage

/* logic/awe_ecc_calc.sv */
// ECC parity accumulator for NAND pages of up to 512 bytes.
// Assumes one take pulse per data word and a clear pulse before each run.
`timescale 1ns/10ps
module awe_ecc_calc (
  input  wire logic                       core_clk,
  input  wire logic                       rstN,
  input  wire logic                       clear,
  input  wire logic                       take,
  input  wire logic                       wide16,
  input  wire logic [awe_pkg::MEM_W-1:0]  data,
  output logic      [awe_pkg::ECC_W-1:0]  result
);

  logic [8:0]                wordIdx;
  logic [awe_pkg::ECC_W-1:0] wordPar;

  // Each data bit has a bit address inside the page; parity pair k splits on address bit k.
  // With 8-bit words bits 0-2 are column parities, with 16-bit words bits 0-3. [R7]
  always_comb
  begin
    logic [11:0] bitAddr;
    bitAddr = 12'h000;
    wordPar = '0;
    for (int b = 0; b < awe_pkg::MEM_W; b++)
    begin
      if (wide16)
        bitAddr = {wordIdx[7:0], 4'(b)};
      else
        bitAddr = {wordIdx, 3'(b)};
      if (wide16 || b < 8)
      begin
        for (int k = 0; k < 12; k++)
        begin
          if (bitAddr[k])
            wordPar[2*k+1] = wordPar[2*k+1] ^ data[b];
          else
            wordPar[2*k] = wordPar[2*k] ^ data[b];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      result  <= '0;
      wordIdx <= 9'h000;
    end
    else if (clear)
    begin
      result  <= '0; // [R6]
      wordIdx <= 9'h000;
    end
    else if (take)
    begin
      result  <= result ^ wordPar; // [R2]
      wordIdx <= wordIdx + 9'h001;
    end
  end

endmodule

/* logic/awe_async_ctrl.sv */
// Asynchronous-memory access sequencer with extended wait, NAND ECC and status,
// data bus parking, reset merging and a maskable interrupt, behind a Wishbone slave.
// Assumes the surrounding controller holds accReq until accDone and supplies selfRefresh.
`timescale 1ns/10ps
module awe_async_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       watchdogRstN,
  input  wire logic                       emulatorRstN,
  input  wire awe_pkg::awe_wb_req_t        wbReq,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic                       accReq,
  input  wire awe_pkg::awe_acc_t           acc,
  input  wire logic                       selfRefresh,
  output logic                            accDone,
  output logic      [awe_pkg::MEM_W-1:0]  accRdata,
  input  wire logic                       waitIn,
  input  wire logic [awe_pkg::MEM_W-1:0]  memDataI,
  output logic      [awe_pkg::MEM_W-1:0]  memDataO,
  output logic                            memDataOe,
  output logic                            memCs2N,
  output logic                            memWeN,
  output logic                            memOeN,
  output logic                            sdramInitReq,
  output logic                            irq
);

  // ==========================================================================
  // Reset merging
  // Any of the three sources resets everything; they are merged asynchronously so that
  // a watchdog or emulator reset acts even without a running clock. [R19]
  logic rstN;
  assign rstN = nrst & watchdogRstN & emulatorRstN;

  // ==========================================================================
  // Registers
  logic                                nandModeEnable;
  logic                                bus16;
  logic                                eccStart;
  logic [awe_pkg::MAX_WAIT_W-1:0]      maxWaitCount;
  logic                                waitPolarity;
  logic                                extWaitEnable;
  logic [awe_pkg::STROBE_W-1:0]        wStrobe;
  logic [awe_pkg::STROBE_W-1:0]        rStrobe;
  logic [awe_pkg::PHASE_W-1:0]         setupLen;
  logic [awe_pkg::PHASE_W-1:0]         holdLen;
  logic [1:0]                          rawStatus;
  logic [1:0]                          maskedStatus;
  logic [1:0]                          irqEnable;
  logic [awe_pkg::ECC_W-1:0]           eccResult;

  // ==========================================================================
  // Pin synchronisers
  logic                                waitMeta;
  logic                                waitSync;
  logic                                waitPrev;
  logic [awe_pkg::MEM_W-1:0]           dataMeta;
  logic [awe_pkg::MEM_W-1:0]           dataSync;

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      // Reset high so that a pin already high after reset shows no false rise. [R10]
      waitMeta <= 1'b1;
      waitSync <= 1'b1;
      waitPrev <= 1'b1;
      dataMeta <= '0;
      dataSync <= '0;
    end
    else
    begin
      waitMeta <= waitIn;
      waitSync <= waitMeta;
      waitPrev <= waitSync;
      dataMeta <= memDataI;
      dataSync <= dataMeta;
    end
  end

  // Raw edge, not polarity-corrected. [R10] [R11]
  logic waitRise;
  assign waitRise = waitSync & ~waitPrev;

  // Polarity only shapes the wait seen by the strobe extension. [R15]
  logic waitAsserted;
  assign waitAsserted = (waitSync == waitPolarity);

  // ==========================================================================
  // Wishbone slave
  // Ack follows one cycle after the request; a write or read side effect happens on
  // the edge where ack is high, which is the edge the master samples it.
  logic busReq;
  logic busTake;
  logic busWrite;
  logic busRead;
  logic [31:0] wrMask;
  logic [31:0] wrBits;

  assign busReq   = wbReq.cyc & wbReq.stb;
  assign busTake  = busReq & ack_o;
  assign busWrite = busTake & wbReq.we;
  assign busRead  = busTake & ~wbReq.we;
  assign wrMask   = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  assign wrBits   = wbReq.dat & wrMask;

  logic [31:0] next_dat;

  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (wbReq.adr == awe_pkg::OFF_NAND_CTRL)
    begin
      next_dat[awe_pkg::NAND_EN_BIT]   = nandModeEnable;
      next_dat[awe_pkg::BUS16_BIT]     = bus16;
      next_dat[awe_pkg::ECC_START_BIT] = eccStart;
    end
    else if (wbReq.adr == awe_pkg::OFF_ECC_RESULT)
      next_dat[awe_pkg::ECC_W-1:0] = eccResult;
    else if (wbReq.adr == awe_pkg::OFF_NAND_READY)
      next_dat[0] = nandModeEnable & waitSync; // [R1] [R9] [R11]
    else if (wbReq.adr == awe_pkg::OFF_WAIT_CFG)
    begin
      next_dat[awe_pkg::MAX_WAIT_LSB +: awe_pkg::MAX_WAIT_W] = maxWaitCount;
      next_dat[awe_pkg::WAIT_POL_BIT]                        = waitPolarity;
    end
    else if (wbReq.adr == awe_pkg::OFF_ASYNC_CFG)
    begin
      next_dat[awe_pkg::W_STROBE_LSB +: awe_pkg::STROBE_W] = wStrobe;
      next_dat[awe_pkg::R_STROBE_LSB +: awe_pkg::STROBE_W] = rStrobe;
      next_dat[awe_pkg::SETUP_LSB +: awe_pkg::PHASE_W]     = setupLen;
      next_dat[awe_pkg::HOLD_LSB +: awe_pkg::PHASE_W]      = holdLen;
      next_dat[awe_pkg::EXT_WAIT_BIT]                      = extWaitEnable;
    end
    else if (wbReq.adr == awe_pkg::OFF_IRQ_RAW)
      next_dat[1:0] = rawStatus;
    else if (wbReq.adr == awe_pkg::OFF_IRQ_MASKED)
      next_dat[1:0] = maskedStatus;
    else if (wbReq.adr == awe_pkg::OFF_IRQ_EN_SET || wbReq.adr == awe_pkg::OFF_IRQ_EN_CLEAR)
      next_dat[1:0] = irqEnable; // [R22]
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= busReq & ~ack_o;
      dat_o <= next_dat;
    end
  end

  // ==========================================================================
  // Configuration registers
  logic eccClear;
  assign eccClear = busWrite && wbReq.adr == awe_pkg::OFF_NAND_CTRL && wrBits[awe_pkg::ECC_START_BIT];

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      nandModeEnable <= 1'b0;
      bus16          <= 1'b0;
      maxWaitCount   <= awe_pkg::MAX_WAIT_RST;
      waitPolarity   <= awe_pkg::WAIT_POL_RST;
      extWaitEnable  <= 1'b0;
      wStrobe        <= awe_pkg::STROBE_RST;
      rStrobe        <= awe_pkg::STROBE_RST;
      setupLen       <= awe_pkg::PHASE_RST;
      holdLen        <= awe_pkg::PHASE_RST;
    end
    else if (busWrite)
    begin
      if (wbReq.adr == awe_pkg::OFF_NAND_CTRL && wbReq.sel[0])
      begin
        nandModeEnable <= wbReq.dat[awe_pkg::NAND_EN_BIT]; // [R1]
        bus16          <= wbReq.dat[awe_pkg::BUS16_BIT];
      end
      else if (wbReq.adr == awe_pkg::OFF_WAIT_CFG)
      begin
        if (wbReq.sel[0])
          maxWaitCount <= wbReq.dat[awe_pkg::MAX_WAIT_LSB +: awe_pkg::MAX_WAIT_W];
        if (wbReq.sel[3])
          waitPolarity <= wbReq.dat[awe_pkg::WAIT_POL_BIT];
      end
      else if (wbReq.adr == awe_pkg::OFF_ASYNC_CFG)
      begin
        if (wbReq.sel[0] && wbReq.sel[1])
        begin
          wStrobe <= wbReq.dat[awe_pkg::W_STROBE_LSB +: awe_pkg::STROBE_W];
          rStrobe <= wbReq.dat[awe_pkg::R_STROBE_LSB +: awe_pkg::STROBE_W];
          setupLen <= wbReq.dat[awe_pkg::SETUP_LSB +: awe_pkg::PHASE_W];
        end
        if (wbReq.sel[2])
          holdLen <= wbReq.dat[awe_pkg::HOLD_LSB +: awe_pkg::PHASE_W];
        if (wbReq.sel[3])
          extWaitEnable <= wbReq.dat[awe_pkg::EXT_WAIT_BIT];
      end
    end
  end

  // Start is set by a write of 1 and dropped by reading the result; writing 0 has no effect
  // so that a control write that only touches the mode bit cannot abort a running page.
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      eccStart <= 1'b0;
    else if (eccClear)
      eccStart <= 1'b1;
    else if (busRead && wbReq.adr == awe_pkg::OFF_ECC_RESULT)
      eccStart <= 1'b0; // [R5]
  end

  // ==========================================================================
  // Access sequencer
  awe_pkg::awe_state_t            state;
  logic [awe_pkg::STROBE_W-1:0]   phaseCnt;
  logic [awe_pkg::MAX_WAIT_W-1:0] extCnt;
  logic                           accWrite;
  logic                           accCs2;
  logic                           readInSelfRefresh;
  logic                           timeoutEvent;
  logic                           strobeEnd;
  logic                           eccTake;
  logic [awe_pkg::MEM_W-1:0]      eccData;

  // Extension applies only at the last programmed strobe cycle. [R12] [R13]
  logic stretch;
  assign stretch = extWaitEnable & waitAsserted & (phaseCnt == '0);

  assign strobeEnd = (state == awe_pkg::ST_STROBE) && (phaseCnt == '0) &&
                     (!stretch || extCnt == maxWaitCount);

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state        <= awe_pkg::ST_IDLE;
      phaseCnt     <= '0;
      extCnt       <= '0;
      accWrite     <= 1'b0;
      accCs2       <= 1'b0;
      accDone      <= 1'b0;
      timeoutEvent <= 1'b0;
    end
    else
    begin
      accDone      <= 1'b0;
      timeoutEvent <= 1'b0;
      case (state)
        awe_pkg::ST_IDLE:
        begin
          if (accReq && !accDone)
          begin
            state    <= awe_pkg::ST_SETUP;
            phaseCnt <= awe_pkg::STROBE_W'(setupLen);
            accWrite <= acc.write;
            accCs2   <= acc.cs2;
          end
        end
        awe_pkg::ST_SETUP:
        begin
          if (phaseCnt == '0)
          begin
            state    <= awe_pkg::ST_STROBE;
            phaseCnt <= accWrite ? wStrobe : rStrobe;
            extCnt   <= '0;
          end
          else
            phaseCnt <= phaseCnt - 1'b1;
        end
        awe_pkg::ST_STROBE:
        begin
          if (strobeEnd)
          begin
            state        <= awe_pkg::ST_HOLD;
            phaseCnt     <= awe_pkg::STROBE_W'(holdLen);
            timeoutEvent <= stretch; // [R14]
          end
          else if (stretch)
            extCnt <= extCnt + 1'b1; // [R13] [R14]
          else
            phaseCnt <= phaseCnt - 1'b1;
        end
        awe_pkg::ST_HOLD:
        begin
          if (phaseCnt == '0)
          begin
            state   <= awe_pkg::ST_IDLE;
            accDone <= 1'b1;
          end
          else
            phaseCnt <= phaseCnt - 1'b1;
        end
        default:
          state <= awe_pkg::ST_IDLE;
      endcase
    end
  end

  // Strobes are active low and registered straight from the next state.
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      memCs2N <= 1'b1;
      memWeN  <= 1'b1;
      memOeN  <= 1'b1;
    end
    else
    begin
      memCs2N <= ~((state == awe_pkg::ST_SETUP && phaseCnt == '0) ||
                   (state == awe_pkg::ST_STROBE && !strobeEnd)) | ~accCs2;
      memWeN  <= ~(((state == awe_pkg::ST_SETUP && phaseCnt == '0) ||
                    (state == awe_pkg::ST_STROBE && !strobeEnd)) & accWrite);
      memOeN  <= ~(((state == awe_pkg::ST_SETUP && phaseCnt == '0) ||
                    (state == awe_pkg::ST_STROBE && !strobeEnd)) & ~accWrite);
    end
  end

  // ==========================================================================
  // Data bus parking
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      memDataO          <= '0;
      memDataOe         <= 1'b1;
      accRdata          <= '0;
      readInSelfRefresh <= 1'b0;
    end
    else if (state == awe_pkg::ST_IDLE && accReq && !accDone)
    begin
      if (acc.write)
      begin
        memDataO  <= acc.wdata;
        memDataOe <= 1'b1; // [R17]
      end
      else
      begin
        memDataOe         <= 1'b0; // [R17]
        readInSelfRefresh <= selfRefresh;
      end
    end
    else if (strobeEnd && !accWrite)
    begin
      accRdata  <= dataSync;
      memDataOe <= ~readInSelfRefresh; // [R17] [R18]
    end
  end

  // ==========================================================================
  // NAND ECC
  assign eccTake = strobeEnd & accCs2 & nandModeEnable & eccStart; // [R1] [R2]
  assign eccData = accWrite ? memDataO : dataSync;

  awe_ecc_calc u_ecc (
    .core_clk (core_clk),
    .rstN     (rstN),
    .clear    (eccClear),
    .take     (eccTake),
    .wide16   (bus16),
    .data     (eccData),
    .result   (eccResult)
  );

  // ==========================================================================
  // Interrupt status
  // A new event in the same cycle as its write-1 clear keeps the bit set.
  logic [1:0] events;
  logic [1:0] rawClear;
  assign events   = {timeoutEvent, waitRise}; // [R10] [R21]
  assign rawClear = (busWrite && wbReq.adr == awe_pkg::OFF_IRQ_RAW) ? wrBits[1:0] : 2'b00;

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rawStatus    <= 2'b00;
      maskedStatus <= 2'b00;
    end
    else
    begin
      rawStatus    <= (rawStatus & ~rawClear) | events; // [R23]
      maskedStatus <= (maskedStatus & ~rawClear) | (events & irqEnable); // [R23]
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      irqEnable <= 2'b00;
    else if (busWrite && wbReq.adr == awe_pkg::OFF_IRQ_EN_SET)
      irqEnable <= irqEnable | wrBits[1:0]; // [R22]
    else if (busWrite && wbReq.adr == awe_pkg::OFF_IRQ_EN_CLEAR)
      irqEnable <= irqEnable & ~wrBits[1:0]; // [R22]
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      irq <= 1'b0;
    else
      irq <= |maskedStatus; // [R21] [R24]
  end

  // ==========================================================================
  // SDRAM initialisation request
  // High out of every reset and dropped at the first clock edge, so the SDRAM
  // side starts its init sequence with no software involvement.
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
      sdramInitReq <= 1'b1; // [R19] [R20]
    else
      sdramInitReq <= 1'b0;
  end

endmodule

/* dv/awe_async_monitor.sv */
// Port checker for the async wait, ECC and interrupt block.
// Bound into the top module; it watches that module's ports only.
`timescale 1ns/10ps
module awe_async_monitor (
  input wire logic                 core_clk,
  input wire logic                 nrst,
  input wire logic                 watchdogRstN,
  input wire logic                 emulatorRstN,
  input wire awe_pkg::awe_wb_req_t wbReq,
  input wire logic                 ack_o,
  input wire logic                 accDone,
  input wire logic                 memOeN,
  input wire logic                 memWeN,
  input wire logic                 memDataOe,
  input wire logic                 sdramInitReq,
  input wire logic                 irq
);
  // ====================
  // Port relations
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!(nrst && watchdogRstN && emulatorRstN));
  init_drop_a: assert property (sdramInitReq && nrst && watchdogRstN && emulatorRstN |=> !sdramInitReq)
    else $error("init request held");
  reset_merge_a: assert property (disable iff (!nrst) !(watchdogRstN && emulatorRstN) |->
    sdramInitReq && !irq && !ack_o) else $error("reset source ignored");
  ack_wait_a: assert property (wbReq.cyc && wbReq.stb && !ack_o |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  done_pulse_a: assert property (accDone |=> !accDone) else $error("done held");
  read_release_a: assert property (!memOeN |-> !memDataOe) else $error("bus driven in read");
  write_drive_a: assert property (!memWeN |-> memDataOe && memOeN) else $error("bus idle in write");
  strobe_bound_a: assert property ($fell(memOeN && memWeN) |-> ##[1:330] memOeN && memWeN)
    else $error("strobe unbounded");
endmodule

bind awe_async_ctrl awe_async_monitor u_awe_async_monitor (.core_clk, .nrst, .watchdogRstN, .emulatorRstN,
  .wbReq, .ack_o, .accDone, .memOeN, .memWeN, .memDataOe, .sdramInitReq, .irq);

/* dv/awe_mem_model.sv */
// Behavioural memory on chip-select space 2: busy level on the wait pin and read data.
// Assumes active-low strobes; the bench sets the busy length and the busy level.
`timescale 1ns/10ps
module awe_mem_model (
  input  wire logic        core_clk,
  input  wire logic        memCs2N,
  input  wire logic        memWeN,
  input  wire logic        memOeN,
  input  wire logic        activeHigh,
  input  wire logic [8:0]  stretch,
  input  wire logic [15:0] rdWord,
  output logic             waitIn,
  output logic [15:0]      memDataI
);
  // ====================
  // Busy and data pins
  logic [8:0]  cnt = 9'h0;
  logic [15:0] last = 16'h0;
  // Busy holds for stretch cycles from strobe start, at the level the bench picks.
  assign waitIn = (!memCs2N && !(memOeN && memWeN) && cnt != 9'h0) ? activeHigh : !activeHigh;
  // Released pins show the inverse of the last word, so stale data never passes.
  assign memDataI = !memOeN ? rdWord : ~last;
  always_ff @(posedge core_clk)
  begin
    cnt <= (memOeN && memWeN) ? stretch : cnt - {8'h0, cnt != 9'h0};
    if (!memOeN)
      last <= rdWord;
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench: Wishbone registers and memory accesses with seeded random data.
// Assumes the memory model on the pins and the bound checker.
`timescale 1ns/10ps
module testbench;
  // ====================
  // Signals and tasks
  awe_pkg::awe_wb_req_t wbReq = '0;
  awe_pkg::awe_acc_t    acc = '0;
  logic [31:0]          dat_o, q;
  logic [15:0]          accRdata, memDataI, memDataO, rdWord = 16'hC3A5;
  logic [8:0]           stretch = 9'h0;
  logic [7:0]           bytes [4];
  logic                 core_clk = 1'b0, nrst = 1'b0, watchdogRstN = 1'b1, emulatorRstN = 1'b1;
  logic                 accReq = 1'b0, selfRefresh = 1'b0, activeHigh = 1'b1;
  logic                 ack_o, accDone, waitIn, memDataOe, memCs2N, memWeN, memOeN, sdramInitReq, irq;
  int                   fails = 0, tests_run = 0, seed = 72;
  awe_async_ctrl u_awe_async_ctrl (.core_clk, .nrst, .watchdogRstN, .emulatorRstN, .wbReq, .dat_o, .ack_o,
    .accReq, .acc, .selfRefresh, .accDone, .accRdata, .waitIn, .memDataI, .memDataO, .memDataOe, .memCs2N,
    .memWeN, .memOeN, .sdramInitReq, .irq);
  awe_mem_model u_awe_mem_model (.core_clk, .memCs2N, .memWeN, .memOeN, .activeHigh, .stretch, .rdWord,
    .waitIn, .memDataI);
  initial
    forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    fails += (got !== exp);
    if (got !== exp) $display("Error %0t: got %h want %h", $time, got, exp);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
    repeat (20) if (ack_o !== 1'b1) @(posedge core_clk);
    fails += (ack_o !== 1'b1);
    q = dat_o;
    wbReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic mem(input logic w, input logic [15:0] d, input logic sr);
    accReq <= 1'b1;
    acc <= '{w, 1'b1, d};
    selfRefresh <= sr;
    repeat (400) if (accDone !== 1'b1) @(posedge core_clk);
    fails += (accDone !== 1'b1);
    accReq <= 1'b0;
    @(posedge core_clk);
  endtask
  // Pair k splits bit addresses on address bit k: even half to bit 2k, odd half to 2k+1.
  function automatic logic [23:0] ecc_of(input logic [7:0] b [4]);
    logic [23:0] e = 24'h0;
    for (int n = 0; n < 32; n++)
      for (int k = 0; k < 12; k++)
        e[2 * k + ((n >> k) & 1)] ^= b[n / 8][n % 8];
    return e;
  endfunction
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(8'h0C, 32'h1000_0080);
    rd(8'h10, 32'h000F_FFFF);
    rd(8'h24, 32'h0);
    $display("Reset values done");
    wb(1'b1, 8'h10, 32'h4000_0104);
    wb(1'b1, 8'h0C, 32'h1000_0004);
    wb(1'b1, 8'h1C, 32'h3);
    wb(1'b1, 8'h20, 32'h1);
    rd(8'h1C, 32'h2);
    rd(8'h20, 32'h2);
    $display("Enables done");
    stretch <= 9'h01E;
    mem(1'b1, 16'h1234, 1'b0);
    rd(8'h14, 32'h3);
    rd(8'h18, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h14, 32'h3);
    rd(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
    stretch <= 9'h002;
    mem(1'b1, 16'h5678, 1'b0);
    rd(8'h14, 32'h1);
    $display("Wait and timeout done");
    wb(1'b1, 8'h00, 32'h1);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h14, 32'h3);
    stretch <= 9'h000;
    activeHigh <= 1'b0;
    wb(1'b1, 8'h0C, 32'h4);
    rd(8'h08, 32'h1);
    rd(8'h14, 32'h1);
    $display("Ready status done");
    // The second pass sends four fresh bytes as two 16-bit words.
    for (int m = 0; m < 2; m++)
    begin
      wb(1'b1, 8'h00, 32'h101 | (m << 1));
      for (int i = 0; i < 4; i++)
        bytes[i] = 8'($random(seed));
      for (int i = 0; i < (4 >> m); i++)
        mem(1'b1, m ? {bytes[2 * i + 1], bytes[2 * i]} : {8'hA5, bytes[i]}, 1'b0);
      rd(8'h04, {8'h0, ecc_of(bytes)});
      rd(8'h00, {30'h0, m[0], 1'b1});
    end
    chk({15'h0, memDataOe, memDataO}, {16'h1, bytes[3], bytes[2]});
    wb(1'b1, 8'h00, 32'h101);
    rd(8'h04, 32'h0);
    $display("ECC done");
    rdWord <= 16'($random(seed));
    mem(1'b0, 16'h0, 1'b0);
    chk({15'h0, memDataOe, accRdata}, {16'h1, rdWord});
    mem(1'b0, 16'h0, 1'b1);
    chk({31'h0, memDataOe}, 32'h0);
    $display("Bus parking done");
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, 8'h1C, 32'h3);
      {watchdogRstN, emulatorRstN} <= (i == 0) ? 2'b01 : 2'b10;
      @(posedge core_clk);
      {watchdogRstN, emulatorRstN} <= 2'b11;
      @(posedge core_clk);
      rd(8'h1C, 32'h0);
      chk({31'h0, sdramInitReq}, 32'h0);
    end
    $display("Reset sources done");
    finish_test();
  end
endmodule
